// *** hdl/ccs_defines.svh ***
// timing counts and field constants for the charger control sequencer
// assumes a 50 MHz system clock
`ifndef CCS_DEFINES_SVH
`define CCS_DEFINES_SVH

`define CCS_CLK_HZ          50000000
`define CCS_SW_FREQ_HZ      1600000
// switching period, rounded down to whole cycles
`define CCS_SW_PERIOD       (`CCS_CLK_HZ / `CCS_SW_FREQ_HZ)
`define CCS_DUTY_MAX_PCT    97
// 97 percent of the period, rounded down
`define CCS_DUTY_MAX        ((`CCS_SW_PERIOD * `CCS_DUTY_MAX_PCT) / 100)
`define CCS_SS_STEPS        8
`define CCS_SS_STEP_US      1600
`define CCS_SS_STEP_CYC     ((`CCS_CLK_HZ / 1000000) * `CCS_SS_STEP_US)
`define CCS_DISCH_MS        1000
`define CCS_DISCH_CYC       ((`CCS_CLK_HZ / 1000) * `CCS_DISCH_MS)
`define CCS_PROBE_MS        500
`define CCS_PROBE_CYC       ((`CCS_CLK_HZ / 1000) * `CCS_PROBE_MS)
`define CCS_SHORT_OFF_MS    1
`define CCS_SHORT_OFF_CYC   ((`CCS_CLK_HZ / 1000) * `CCS_SHORT_OFF_MS)
`define CCS_OVP_MS          30
`define CCS_OVP_CYC         ((`CCS_CLK_HZ / 1000) * `CCS_OVP_MS)
`define CCS_REFRESH_CYC     2
`define CCS_BLINK_CYC       12500000
`define CCS_ISET_W          8
`define CCS_PRECHG_DIV      10
`define CCS_PROBE_CODE      8'h0C

`endif

// *** hdl/ccs_pkg.sv ***
// types for the charger control sequencer
package ccs_pkg;
  typedef enum logic [2:0] {
    CCS_DETECT_DISCH,
    CCS_DETECT_PROBE,
    CCS_WAIT_TEMP,
    CCS_CHARGE,
    CCS_SHORT_OFF,
    CCS_DISABLED
  } ccs_state_t;
endpackage

// *** hdl/ccs_timer.sv ***
// down-counting timer: load, run, one-cycle expiry pulse
// assumes load and run come from the same clock domain
`timescale 1ns/1ps
`default_nettype none
module ccs_timer #(
  parameter int W = 32
) (
  // clock and reset
  input  wire logic         sys_clk,
  input  wire logic         rst,
  // control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  input  wire logic         run,
  // status
  output logic              expired
);
  logic [W-1:0] count;
  logic [W-1:0] next_count;
  logic         next_expired;

  always_comb
  begin
    next_count   = count;
    next_expired = 1'b0;
    if (load)
      next_count = load_val;
    else if (run && count != '0)
    begin
      next_count   = count - 1'b1;
      next_expired = (count == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      count   <= '0;
      expired <= 1'b0;
    end
    else
    begin
      count   <= next_count;
      expired <= next_expired;
    end
  end
endmodule
`default_nettype wire

// *** hdl/ccs_top.sv ***
// charger control sequencer: switching cycle, soft-start, battery detect, protections
// assumes comparator results arrive asynchronously and are synchronised here
`timescale 1ns/1ps
`default_nettype none
`include "ccs_defines.svh"
module ccs_top
  import ccs_pkg::*;
#(
  parameter int DISCH_CYC     = `CCS_DISCH_CYC,
  parameter int PROBE_CYC     = `CCS_PROBE_CYC,
  parameter int OVP_CYC       = `CCS_OVP_CYC,
  parameter int SS_STEP_CYC   = `CCS_SS_STEP_CYC,
  parameter int BLINK_CYC     = `CCS_BLINK_CYC,
  parameter int SHORT_OFF_CYC = `CCS_SHORT_OFF_CYC
) (
  // clock and reset
  input  wire logic                  sys_clk,
  input  wire logic                  rst,
  // programmed charge current
  input  wire logic [`CCS_ISET_W-1:0] charge_current_set,
  // comparators (asynchronous)
  input  wire logic                  pwm_cmp_off,
  input  wire logic                  peak_overcurrent,
  input  wire logic                  charge_overcurrent,
  input  wire logic                  sense_below_5mv,
  input  wire logic                  bootstrap_low,
  input  wire logic                  discontinuous_conduction,
  input  wire logic                  below_recharge,
  input  wire logic                  below_low_battery_threshold,
  input  wire logic                  battery_short,
  input  wire logic                  battery_overvoltage,
  input  wire logic                  above_cold_limit,
  input  wire logic                  below_hot_start_limit,
  input  wire logic                  below_hot_cutoff_limit,
  input  wire logic                  die_above_150c,
  input  wire logic                  die_below_130c,
  input  wire logic                  switch_short,
  input  wire logic                  adapter_present,
  // drives
  output logic                       high_side_on,
  output logic                       low_side_on,
  output logic                       discharge_on,
  output logic                       adapter_switch,
  output logic [`CCS_ISET_W-1:0]     current_target,
  // status
  output logic                       status_on,
  output logic                       battery_present,
  output logic                       die_overtemp_shutdown
);
  localparam int NS = 17;
  localparam int PW = 6;

  // two-stage synchronisers for all comparator inputs
  logic [NS-1:0] raw_in;
  logic [NS-1:0] sync1;
  logic [NS-1:0] sync2;
  assign raw_in = {pwm_cmp_off, peak_overcurrent, charge_overcurrent, sense_below_5mv,
                   bootstrap_low, discontinuous_conduction, below_recharge,
                   below_low_battery_threshold, battery_short, battery_overvoltage,
                   above_cold_limit, below_hot_start_limit, below_hot_cutoff_limit,
                   die_above_150c, die_below_130c, switch_short, adapter_present};
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      sync1 <= '0;
      sync2 <= '0;
    end
    else
    begin
      sync1 <= raw_in;
      sync2 <= sync1;
    end
  end
  logic s_pwm_off, s_peak_oc, s_chg_oc, s_5mv, s_boot_low, s_dcm, s_below_rech;
  logic s_below_low, s_short, s_ovp, s_cold_ok, s_hot_start_ok, s_hot_cut_ok;
  logic s_die_hot, s_die_cool, s_sw_short, s_adapter;
  assign {s_pwm_off, s_peak_oc, s_chg_oc, s_5mv, s_boot_low, s_dcm, s_below_rech,
          s_below_low, s_short, s_ovp, s_cold_ok, s_hot_start_ok, s_hot_cut_ok,
          s_die_hot, s_die_cool, s_sw_short, s_adapter} = sync2;

  // switching cycle counter
  logic [PW-1:0] phase;
  logic [PW-1:0] next_phase;
  logic          cycle_start;
  always_comb
  begin
    next_phase = (phase == PW'(`CCS_SW_PERIOD - 1)) ? '0 : phase + 1'b1;
  end
  assign cycle_start = (phase == '0);

  // fault and supervision state
  logic sc_latch, next_sc_latch;
  logic die_hot, next_die_hot;
  logic ovp_inhibit, next_ovp_inhibit;
  logic adapter_prev, next_adapter_prev;
  logic ovp_expired;
  logic ovp_run;

  always_comb
  begin
    next_adapter_prev = s_adapter;
    next_sc_latch     = sc_latch;
    if (s_sw_short)
      next_sc_latch = 1'b1;
    else if (s_adapter && !adapter_prev)
      next_sc_latch = 1'b0;
    next_die_hot = die_hot;
    if (s_die_hot)
      next_die_hot = 1'b1;
    else if (s_die_cool)
      next_die_hot = 1'b0;
    // takes effect at the next cycle start
    next_ovp_inhibit = ovp_inhibit;
    if (cycle_start)
      next_ovp_inhibit = s_ovp;
  end
  assign ovp_run = s_ovp;

  ccs_timer #(.W(32)) u_ovp_timer (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .load     (!s_ovp),
    .load_val (32'(OVP_CYC)),
    .run      (ovp_run),
    .expired  (ovp_expired)
  );

  // sequencer
  ccs_state_t state, next_state;
  // reset is no state change, so seq_arm loads the timer once after it
  logic       seq_arm, next_state_entry;
  logic       step_expired;
  logic       seq_expired;
  logic [31:0] seq_load_val;
  logic [3:0] ss_step, next_ss_step;
  logic       precharge, next_precharge;
  logic       was_below_rech, next_was_below_rech;

  always_comb
  begin
    next_state          = state;
    next_ss_step        = ss_step;
    next_precharge      = precharge;
    next_was_below_rech = s_below_rech;
    unique case (state)
      CCS_DETECT_DISCH:
      begin
        if (s_below_low)
          next_state = CCS_DETECT_PROBE;
        else if (seq_expired)
          next_state = CCS_WAIT_TEMP;
      end
      CCS_DETECT_PROBE:
      begin
        if (!s_below_rech)
          next_state = CCS_DETECT_DISCH;
        else if (seq_expired)
          next_state = CCS_WAIT_TEMP;
      end
      CCS_WAIT_TEMP:
      begin
        if (s_cold_ok && s_hot_start_ok)
        begin
          next_state = CCS_CHARGE;
          next_ss_step = 4'h1;
        end
      end
      CCS_CHARGE:
      begin
        if (step_expired && ss_step != 4'(`CCS_SS_STEPS))
          next_ss_step = ss_step + 1'b1;
        if (!(s_cold_ok && s_hot_cut_ok))
          next_state = CCS_WAIT_TEMP;
        if (s_short)
        begin
          next_state     = CCS_SHORT_OFF;
          next_precharge = 1'b1;
        end
        if (s_below_rech && !was_below_rech)
        begin
          next_state     = CCS_DETECT_DISCH;
          next_precharge = 1'b0;
        end
      end
      CCS_SHORT_OFF:
      begin
        if (seq_expired)
        begin
          next_state   = CCS_CHARGE;
          next_ss_step = 4'h1;
        end
      end
      CCS_DISABLED:
      begin
        next_state = CCS_DISABLED;
      end
      default:
      begin
        next_state = CCS_DETECT_DISCH;
      end
    endcase
    if (ovp_expired)
      next_state = CCS_DISABLED;
    next_state_entry = (next_state != state);
  end

  always_comb
  begin
    unique case (next_state)
      CCS_DETECT_DISCH: seq_load_val = 32'(DISCH_CYC);
      CCS_DETECT_PROBE: seq_load_val = 32'(PROBE_CYC);
      CCS_SHORT_OFF:    seq_load_val = 32'(SHORT_OFF_CYC);
      // reload costs one cycle, so each step lasts exactly SS_STEP_CYC
      default:          seq_load_val = 32'(SS_STEP_CYC - 1);
    endcase
  end

  ccs_timer #(.W(32)) u_seq_timer (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .load     (next_state_entry || step_expired || seq_arm),
    .load_val (seq_load_val),
    .run      (1'b1),
    .expired  (seq_expired)
  );
  assign step_expired = seq_expired && (state == CCS_CHARGE);

  // current target, tenth of programmed current after short
  logic [`CCS_ISET_W-1:0] full_target;
  logic [`CCS_ISET_W+3:0] ramp_prod;
  logic [`CCS_ISET_W-1:0] next_current_target;
  always_comb
  begin
    full_target = precharge ? `CCS_ISET_W'(charge_current_set / `CCS_PRECHG_DIV)
                            : charge_current_set;
    ramp_prod   = full_target * ss_step;
    next_current_target = '0;
    if (state == CCS_DETECT_PROBE)
      next_current_target = `CCS_PROBE_CODE;
    else if (state == CCS_CHARGE)
      next_current_target = ramp_prod[`CCS_ISET_W+2:3];
  end

  // gate drive
  logic run_ok;
  logic hs_blocked, next_hs_blocked;
  logic ls_blocked, next_ls_blocked;
  logic [1:0] refresh_cnt, next_refresh_cnt;
  logic next_high_side_on, next_low_side_on;
  always_comb
  begin
    // suspension, the short latch and die overheating disable both switches
    run_ok = ((state == CCS_CHARGE) || (state == CCS_DETECT_PROBE))
             && !sc_latch && !die_hot;
    next_hs_blocked  = hs_blocked;
    next_ls_blocked  = ls_blocked;
    next_refresh_cnt = (refresh_cnt != '0) ? refresh_cnt - 1'b1 : '0;
    if (cycle_start)
    begin
      next_hs_blocked = 1'b0;
      next_ls_blocked = 1'b0;
    end
    // peak limit for rest of cycle
    if (s_peak_oc)
      next_hs_blocked = 1'b1;
    // turn-on only at a cycle start, so no off-grid or sliver pulses
    if (s_chg_oc || s_pwm_off || next_ovp_inhibit || !run_ok)
      next_hs_blocked = 1'b1;
    if (s_5mv)
      next_ls_blocked = 1'b1;
    if (s_dcm && s_boot_low && refresh_cnt == '0)
      next_refresh_cnt = 2'(`CCS_REFRESH_CYC);
    // duty limit; the blocks above end the on-time
    next_high_side_on = run_ok && (phase < PW'(`CCS_DUTY_MAX)) && !next_hs_blocked;
    next_low_side_on  = run_ok && !next_high_side_on && !s_short
                        && ((!next_ls_blocked && !s_dcm) || (refresh_cnt != '0));
  end

  logic [23:0] blink_cnt, next_blink_cnt;
  logic        blink, next_blink;
  logic        next_status_on;
  always_comb
  begin
    next_blink_cnt = blink_cnt + 1'b1;
    next_blink     = blink;
    if (blink_cnt == 24'(BLINK_CYC - 1))
    begin
      next_blink_cnt = '0;
      next_blink     = !blink;
    end
    next_status_on = sc_latch ? blink : (state == CCS_CHARGE);
  end

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      phase                 <= '0;
      sc_latch              <= 1'b0;
      die_hot               <= 1'b0;
      ovp_inhibit           <= 1'b0;
      adapter_prev          <= 1'b0;
      state                 <= CCS_DETECT_DISCH;
      seq_arm               <= 1'b1;
      ss_step               <= '0;
      precharge             <= 1'b0;
      was_below_rech        <= 1'b0;
      hs_blocked            <= 1'b0;
      ls_blocked            <= 1'b0;
      refresh_cnt           <= '0;
      blink_cnt             <= '0;
      blink                 <= 1'b0;
      high_side_on          <= 1'b0;
      low_side_on           <= 1'b0;
      discharge_on          <= 1'b0;
      adapter_switch        <= 1'b0;
      current_target        <= '0;
      status_on             <= 1'b0;
      battery_present       <= 1'b0;
      die_overtemp_shutdown <= 1'b0;
    end
    else
    begin
      phase                 <= next_phase;
      sc_latch              <= next_sc_latch;
      die_hot               <= next_die_hot;
      ovp_inhibit           <= next_ovp_inhibit;
      adapter_prev          <= next_adapter_prev;
      state                 <= next_state;
      seq_arm               <= 1'b0;
      ss_step               <= next_ss_step;
      precharge             <= next_precharge;
      was_below_rech        <= next_was_below_rech;
      hs_blocked            <= next_hs_blocked;
      ls_blocked            <= next_ls_blocked;
      refresh_cnt           <= next_refresh_cnt;
      blink_cnt             <= next_blink_cnt;
      blink                 <= next_blink;
      high_side_on          <= next_high_side_on;
      low_side_on           <= next_low_side_on;
      discharge_on          <= (next_state == CCS_DETECT_DISCH);
      // adapter switch stays on through the short latch
      adapter_switch        <= s_adapter;
      current_target        <= next_current_target;
      status_on             <= next_status_on;
      battery_present       <= (next_state == CCS_WAIT_TEMP) || (next_state == CCS_CHARGE)
                               || (next_state == CCS_SHORT_OFF);
      die_overtemp_shutdown <= next_die_hot;
    end
  end
endmodule
`default_nettype wire

// *** verification/ccs_top_sva.sv ***
// port assertions for the charger control sequencer
// assumes one clock and comparator inputs passing a two-stage synchroniser
`timescale 1ns/1ps
`default_nettype none
`include "ccs_defines.svh"
module ccs_top_sva (
  // clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // comparator inputs
  input wire logic peak_overcurrent,
  input wire logic charge_overcurrent,
  input wire logic battery_short,
  input wire logic battery_overvoltage,
  input wire logic above_cold_limit,
  input wire logic die_above_150c,
  input wire logic switch_short,
  input wire logic adapter_present,
  // drives and status
  input wire logic high_side_on,
  input wire logic low_side_on,
  input wire logic adapter_switch,
  input wire logic battery_present,
  input wire logic die_overtemp_shutdown
);
  localparam int PERIOD = `CCS_SW_PERIOD;
  localparam int DUTY   = `CCS_DUTY_MAX;
  int   hs_run;
  int   since_rise;
  int   ov_run;
  logic hs_q;
  logic rise_seen;
  // run length of the high side and spacing of its turn-on edges
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      hs_run <= 0;
      since_rise <= 0;
      hs_q <= 1'b0;
      rise_seen <= 1'b0;
      ov_run <= 0;
    end
    else
    begin
      hs_q <= high_side_on;
      hs_run <= high_side_on ? hs_run + 1 : 0;
      since_rise <= (high_side_on && !hs_q) ? 1 : since_rise + 1;
      rise_seen <= rise_seen | (high_side_on && !hs_q);
      ov_run <= battery_overvoltage ? ov_run + 1 : 0;
    end
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // five samples cover the synchroniser plus a state step
  sequence s_hot;
    die_above_150c [*5];
  endsequence
  sequence s_latched;
    (switch_short && adapter_present) [*5];
  endsequence
  sequence s_cold;
    (battery_present && !above_cold_limit) [*5];
  endsequence
  a_period_fixed: assert property (
    high_side_on && !hs_q && rise_seen |-> since_rise % PERIOD == 0)
    else $error("high side turn-on off the switching grid");
  a_duty_limit: assert property (hs_run <= DUTY)
    else $error("high side on longer than the duty limit");
  a_peak_cutoff: assert property (peak_overcurrent [*4] |-> !high_side_on)
    else $error("high side on during peak overcurrent");
  a_overcurrent_block: assert property (charge_overcurrent [*4] |-> !high_side_on)
    else $error("high side on during charge overcurrent");
  a_short_nonsync: assert property (battery_short [*5] |-> !low_side_on)
    else $error("low side used during battery short");
  // the inhibit waits for the next switching cycle: allow one period plus sync
  a_ovp_inhibit: assert property (ov_run > PERIOD + 3 |-> !high_side_on)
    else $error("high side on during overvoltage");
  a_cold_suspend: assert property (s_cold |-> !high_side_on && !low_side_on)
    else $error("switching while thermistor is cold");
  a_overtemp_off: assert property (
    s_hot |-> die_overtemp_shutdown && !high_side_on && !low_side_on)
    else $error("converter running above die limit");
  a_latch_adapter: assert property (
    s_latched |-> adapter_switch && !high_side_on && !low_side_on)
    else $error("short latch did not stop the charger");
endmodule
bind ccs_top ccs_top_sva u_sva (
  .sys_clk, .rst, .peak_overcurrent, .charge_overcurrent, .battery_short,
  .battery_overvoltage, .above_cold_limit, .die_above_150c, .switch_short,
  .adapter_present, .high_side_on, .low_side_on, .adapter_switch, .battery_present,
  .die_overtemp_shutdown
);
`default_nettype wire

// *** verification/ccs_battery.sv ***
// battery pack model driving the two battery-level comparators
// assumes one clock; the level is coarse, only threshold crossings matter
`timescale 1ns/1ps
`default_nettype none
module ccs_battery (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic rst,
  // pack conditions set by the bench
  input  wire logic present,
  input  wire logic drain,
  // device drive
  input  wire logic discharge_on,
  // comparator results
  output logic      below_recharge,
  output logic      below_low_battery_threshold
);
  logic [3:0] level;
  logic [3:0] next_level;
  // an empty node follows the sink down and the probe up; a pack ignores the sink, falls while drained and refills otherwise
  always_comb
  begin
    if (present ? drain : discharge_on)
      next_level = (level == 4'h0) ? level : level - 4'h1;
    else
      next_level = (level == 4'hF) ? level : level + 4'h1;
  end
  always_ff @(posedge sys_clk)
  begin
    level <= rst ? 4'hF : next_level;
  end
  assign below_recharge = (level < 4'hA);
  assign below_low_battery_threshold = (level < 4'h4);
endmodule
`default_nettype wire

// *** verification/testbench.sv ***
// self-checking bench for the charger control sequencer
// assumes the battery model drives the battery-level comparators
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin n_errors++; \
  $display("mismatch %s expected %0h seen %0h", nm, ex, got); end end
`define WAITV(c, n) for (int k = 0; k < (n) && !(c); k++) @(negedge sys_clk);
`define HOLD(s, n) begin @(posedge sys_clk); s <= 1'b1; repeat (n) @(posedge sys_clk); \
  s <= 1'b0; end
module testbench;
  localparam int SS = 20;
  int         n_errors = 0;
  int         n_tests = 0;
  int         seed = 32'hf7b6;
  int         c;
  logic       sys_clk = 1'b0;
  logic       rst = 1'b1;
  logic [7:0] charge_current_set = 8'h80;
  logic       pwm_cmp_off = 1'b0, peak_overcurrent = 1'b0, charge_overcurrent = 1'b0;
  logic       sense_below_5mv = 1'b0, bootstrap_low = 1'b0, discontinuous_conduction = 1'b0;
  logic       battery_short = 1'b0, battery_overvoltage = 1'b0, above_cold_limit = 1'b0;
  logic       below_hot_start_limit = 1'b1, below_hot_cutoff_limit = 1'b1;
  logic       die_above_150c = 1'b0, die_below_130c = 1'b1, switch_short = 1'b0;
  logic       adapter_present = 1'b1, present = 1'b0, drain = 1'b0;
  wire        below_recharge, below_low_battery_threshold;
  logic       high_side_on, low_side_on, discharge_on, adapter_switch;
  logic [7:0] current_target;
  logic       status_on, battery_present, die_overtemp_shutdown;
  always #10 sys_clk = ~sys_clk;
  ccs_battery u_pack (.sys_clk, .rst, .present, .drain, .discharge_on,
    .below_recharge, .below_low_battery_threshold);
  ccs_top #(.DISCH_CYC(200), .PROBE_CYC(100), .OVP_CYC(50), .SS_STEP_CYC(SS),
    .BLINK_CYC(10), .SHORT_OFF_CYC(30)) DUT (.sys_clk, .rst, .charge_current_set,
    .pwm_cmp_off, .peak_overcurrent, .charge_overcurrent, .sense_below_5mv, .bootstrap_low,
    .discontinuous_conduction, .below_recharge, .below_low_battery_threshold, .battery_short,
    .battery_overvoltage, .above_cold_limit, .below_hot_start_limit, .below_hot_cutoff_limit,
    .die_above_150c, .die_below_130c, .switch_short, .adapter_present, .high_side_on,
    .low_side_on, .discharge_on, .adapter_switch, .current_target, .status_on,
    .battery_present, .die_overtemp_shutdown);
  function automatic logic [7:0] step_val(input logic [7:0] b, input int k);
    return 8'((int'(b) * k) / 8);
  endfunction
  task automatic complete_run;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic do_reset;
    @(posedge sys_clk);
    rst <= 1'b1;
    repeat (7) @(posedge sys_clk);
    @(negedge sys_clk);
    `CHK("drives in reset", 1'b0, high_side_on | low_side_on | discharge_on)
    @(posedge sys_clk);
    rst <= 1'b0;
  endtask
  task automatic count_hs(input int n, output int cnt);
    cnt = 0;
    repeat (n)
    begin
      @(negedge sys_clk);
      cnt += (high_side_on === 1'b1);
    end
  endtask
  // every step must land on the expected code; steps 1 to 7 must last exactly one step period
  task automatic ramp(input logic [7:0] base);
    int wt;
    for (int k = 1; k <= 8; k++)
    begin
      wt = 0;
      while (current_target !== step_val(base, k) && wt < 100)
      begin
        @(negedge sys_clk);
        wt++;
      end
      `CHK("target step", step_val(base, k), current_target)
      if (k > 1)
        `CHK("step length", SS, wt)
    end
  endtask
  initial
  begin
    #(20ns * 30000);
    n_errors++;
    complete_run();
  end
  initial
  begin
    int tg;
    logic prev;
    @(posedge sys_clk);
    charge_current_set <= 8'h80 | 8'($random(seed));
    do_reset();
    `WAITV(discharge_on, 5)
    `CHK("discharge at start", 1'b1, discharge_on)
    `WAITV(!discharge_on, 60)
    `CHK("discharge removed", 1'b0, discharge_on)
    repeat (3) @(negedge sys_clk);
    `CHK("probe current", 8'h0C, current_target)
    `WAITV(discharge_on, 60)
    `CHK("detect restart", 1'b1, discharge_on)
    `CHK("no battery", 1'b0, battery_present)
    @(posedge sys_clk);
    present <= 1'b1;
    `WAITV(battery_present, 500)
    `CHK("battery found", 1'b1, battery_present)
    count_hs(100, c);
    `CHK("start held cold", 0, c)
    @(posedge sys_clk);
    above_cold_limit <= 1'b1;
    ramp(charge_current_set);
    repeat (300)
    begin
      @(posedge sys_clk);
      {pwm_cmp_off, peak_overcurrent, charge_overcurrent, sense_below_5mv, bootstrap_low,
        discontinuous_conduction} <= 6'($random(seed));
    end
    @(posedge sys_clk);
    {pwm_cmp_off, peak_overcurrent, charge_overcurrent, sense_below_5mv, bootstrap_low,
      discontinuous_conduction} <= 6'h00;
    below_hot_cutoff_limit <= 1'b0;
    below_hot_start_limit <= 1'b0;
    repeat (6) @(negedge sys_clk);
    `CHK("hot suspend", 2'b00, {high_side_on, low_side_on})
    @(posedge sys_clk);
    below_hot_cutoff_limit <= 1'b1;
    count_hs(100, c);
    `CHK("no resume warm", 0, c)
    @(posedge sys_clk);
    below_hot_start_limit <= 1'b1;
    ramp(charge_current_set);
    @(posedge sys_clk);
    die_above_150c <= 1'b1;
    die_below_130c <= 1'b0;
    repeat (10) @(posedge sys_clk);
    die_above_150c <= 1'b0;
    repeat (8) @(negedge sys_clk);
    `CHK("die hysteresis", 1'b1, die_overtemp_shutdown)
    @(posedge sys_clk);
    die_below_130c <= 1'b1;
    repeat (8) @(negedge sys_clk);
    `CHK("die cooled", 1'b0, die_overtemp_shutdown)
    `HOLD(battery_short, 10)
    repeat (6) @(negedge sys_clk);
    `CHK("short stop", 2'b00, {high_side_on, low_side_on})
    repeat (300) @(negedge sys_clk);
    `CHK("precharge", 8'(charge_current_set / 10), current_target)
    @(posedge sys_clk);
    drain <= 1'b1;
    `WAITV(discharge_on, 200)
    `CHK("redetect", 1'b1, discharge_on)
    @(posedge sys_clk);
    drain <= 1'b0;
    `WAITV(current_target === step_val(charge_current_set, 1), 600)
    ramp(charge_current_set);
    `HOLD(battery_overvoltage, 30)
    repeat (10) @(posedge sys_clk);
    `HOLD(battery_overvoltage, 30)
    `WAITV(high_side_on, 100)
    `CHK("short ovp", 1'b1, high_side_on)
    `HOLD(battery_overvoltage, 100)
    count_hs(200, c);
    `CHK("ovp disable", 0, c)
    do_reset();
    `WAITV(high_side_on, 800)
    `HOLD(switch_short, 10)
    repeat (8) @(negedge sys_clk);
    `CHK("adapter kept", 1'b1, adapter_switch)
    tg = 0;
    prev = status_on;
    repeat (100)
    begin
      @(negedge sys_clk);
      tg += (status_on !== prev);
      prev = status_on;
    end
    `CHK("blink", 1'b1, (tg >= 9) && (tg <= 11))
    count_hs(100, c);
    `CHK("latched off", 0, c)
    @(posedge sys_clk);
    adapter_present <= 1'b0;
    repeat (10) @(posedge sys_clk);
    adapter_present <= 1'b1;
    `WAITV(high_side_on, 800)
    `CHK("replug clears", 1'b1, high_side_on)
    complete_run();
  end
endmodule
`default_nettype wire
